/* File: shared/link_pkg.sv */
// Constants, field layout and state codes for the link control and status registers.
// Assumes a configuration-space access port with dword addresses and byte enables.
package link_pkg;

    // Register byte offsets in configuration space.
    localparam logic [11:0] LINK_CTRL_OFS   = 12'h0B0;
    localparam logic [11:0] LINK_STAT_OFS   = 12'h0B2;

    // Values after reset.
    localparam logic [15:0] LINK_CTRL_RESET = 16'h0000;
    localparam logic [15:0] LINK_STAT_RESET = 16'h1000;

    // Control field positions.
    localparam int CTL_SHARED_REFCLK = 6;
    localparam int CTL_RETRAIN       = 5;
    localparam int CTL_LINK_OFF      = 4;
    localparam int CTL_COMPL_BOUND   = 3;
    localparam int CTL_IDLE_PWR_LO   = 0;

    // Status field positions.
    localparam int STS_AUTO_BW       = 15;
    localparam int STS_BW_MGMT       = 14;
    localparam int STS_DLINK_UP      = 13;
    localparam int STS_SLOT_REFCLK   = 12;
    localparam int STS_TRAINING      = 11;
    localparam int STS_UNDEFINED     = 10;
    localparam int STS_WIDTH_LO      = 4;
    localparam int STS_RATE_LO       = 0;

    // Reset and hardwired values of single fields.
    localparam logic       SLOT_REFCLK_RESET = 1'h1;
    localparam logic       COMPL_BOUND_64B   = 1'h0;
    localparam logic [5:0] WIDTH_RESET       = 6'h00;
    localparam logic [3:0] RATE_RESET        = 4'h0;

    // Consecutive autonomous training sets needed before the flag is raised.
    localparam logic [3:0] AUTO_TS_COUNT     = 4'h8;

    // Training state machine states as reported by the physical layer.
    typedef enum logic [3:0] {
        LT_DETECT   = 4'h0,
        LT_POLLING  = 4'h1,
        LT_CONFIG   = 4'h2,
        LT_L0       = 4'h3,
        LT_RECOVERY = 4'h4,
        LT_L1       = 4'h5,
        LT_L0S      = 4'h6,
        LT_DISABLED = 4'h7,
        LT_HOTRESET = 4'h8
    } ltssm_t;

    // Software retrain tracker, Gray coded along idle, wait, train.
    typedef enum logic [1:0] {
        TRK_IDLE  = 2'b00,
        TRK_WAIT  = 2'b01,
        TRK_TRAIN = 2'b11
    } trk_t;

endpackage

/* File: shared/ts_if.sv */
// Carries received training-set events to the autonomous-change counter and its result back.
// Assumes both ends run on the core clock.
`timescale 1ns/1ns
interface ts_if;
    logic ts_valid;
    logic ts_auto;
    logic auto_hit;

    modport feed  (output ts_valid, output ts_auto, input auto_hit);
    modport count (input ts_valid, input ts_auto, output auto_hit);
endinterface

/* File: rtl/ts_auto_counter.sv */
// Counts consecutive received training sets that carry the autonomous change mark.
// Assumes one ts_valid pulse per received TS1 or TS2 set, on the core clock.
`timescale 1ns/1ns
module ts_auto_counter
    import link_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    ts_if.count       ts
);

    logic [3:0] run_r;
    logic [3:0] run_nxt;
    logic       hit_r;
    logic       reach;

    // A marked set extends the run, an unmarked set breaks it; the run saturates.
    assign reach   = ts.ts_valid && ts.ts_auto && (run_r == AUTO_TS_COUNT - 4'h1);
    assign run_nxt = !ts.ts_valid ? run_r :
                     !ts.ts_auto ? 4'h0 :
                     (run_r == AUTO_TS_COUNT) ? run_r : run_r + 4'h1;

    // Run counter and a single pulse when the eighth marked set arrives.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_r <= 4'h0;
            hit_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            hit_r <= reach;
        end
    end

    assign ts.auto_hit = hit_r;

endmodule

/* File: rtl/link_ctrl_status.sv */
// Link control (lower bits) and link status registers of one root port.
// Assumes a configuration access port on the core clock and a training state
// machine and data-link state machine on the same clock driving the status inputs.
//
// How it works
// - Bit 6 selects shared (1) or separate (0) reference clocks, read/write.
// - Advertised fast-training-sequence count follows the shared clock bit.
// - Writing 1 to bit 5 sends the training machine into Recovery.
// - Bit 5 always reads 0 and clears itself.
// - Bit 4 set forces the link toward Disabled through Recovery.
// - Any change of bit 4 triggers an automatic retrain.
// - Bit 4 reads back the written value regardless of link state.
// - Bit 3 is hardwired 0, a 64 byte completion boundary.
// - Two-bit idle power field; 10 or 11 enable L1 entry, 01 reserved.
// - Autonomous bandwidth flag sets on own speed or width change without link down.
// - Eight consecutive marked training sets set the autonomous bandwidth flag.
// - A downstream autonomous change reported by the physical layer sets it too.
// - Bandwidth management flag sets when a software retrain completes without link down.
// - A write of 1 to bit 5 leads to the management flag, even mid-training, unless the link goes down before training ends.
// - Reliability corrections and non-autonomous downstream changes also set it.
// - Bit 13 reads 1 while the data link is active, registered one cycle behind dl_active.
// - Bit 12 resets to 1: slot uses the connector reference clock.
// - Bit 11 shows training in Configuration, Recovery, or a pending retrain.
// - Bits 9:4 give negotiated lane count, captured in L0 or L1.
// - Bits 3:0 give negotiated rate: 0001b 2.5 GT/s, 0010b 5 GT/s.
`timescale 1ns/1ns
module link_ctrl_status
    import link_pkg::*;
#(
    parameter logic [7:0] NFTS_SHARED   = 8'h20,
    parameter logic [7:0] NFTS_SEPARATE = 8'h80
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_rd_valid,
    input  wire ltssm_t      ltssm_state,
    input  wire logic        dl_active,
    input  wire logic        dl_down,
    input  wire logic [5:0]  neg_width,
    input  wire logic [3:0]  neg_speed,
    input  wire logic        ts_valid,
    input  wire logic        ts_auto_change,
    input  wire logic        hw_auto_bw_change,
    input  wire logic        hw_reliab_bw_change,
    input  wire logic        phy_dsp_bw_change,
    input  wire logic        phy_dsp_autonomous,
    output logic             retrain_go,
    output logic             link_off_request,
    output logic             shared_refclk_select,
    output logic [7:0]       nfts_advertised,
    output logic             l1_entry_enable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True when the state is one in which the link is up and fields are valid.
    function automatic logic link_up(input ltssm_t st);
        link_up = (st == LT_L0) || (st == LT_L1);
    endfunction

    // True when the state is one of the training states.
    function automatic logic in_training(input ltssm_t st);
        in_training = (st == LT_CONFIG) || (st == LT_RECOVERY);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.

    logic        shared_refclk_r;
    logic        link_off_r;
    logic [1:0]  idle_power_level_r;
    logic        retrain_go_r;
    logic        auto_bw_change_flag_r;
    logic        bw_mgmt_change_flag_r;
    logic        dlink_up_indicator_r;
    logic        training_in_progress_r;
    logic [5:0]  negotiated_lane_count_r;
    logic [3:0]  negotiated_rate_r;
    logic [31:0] rdata_r;
    logic        rd_valid_r;
    logic [7:0]  nfts_r;
    logic        l1_enable_r;
    trk_t        trk_r;
    trk_t        trk_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and write strobes.

    // Both registers share one dword; low byte lanes hold control, high lanes status.
    logic        hit_dw;
    logic        wr_ctl_lo;
    logic        wr_sts_hi;
    logic        retrain_wr;
    logic        link_off_nxt;
    logic        link_off_flip;
    logic [15:0] ctl_word;
    logic [15:0] sts_word;

    assign hit_dw     = (cfg_addr[11:2] == LINK_CTRL_OFS[11:2]);
    assign wr_ctl_lo  = cfg_wr && hit_dw && cfg_be[0];
    assign wr_sts_hi  = cfg_wr && hit_dw && cfg_be[3];
    assign retrain_wr = wr_ctl_lo && cfg_wdata[CTL_RETRAIN];

    // Next value of the disable bit and whether a write changes it.
    assign link_off_nxt  = wr_ctl_lo ? cfg_wdata[CTL_LINK_OFF] : link_off_r;
    assign link_off_flip = link_off_nxt != link_off_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Control bits.

    // Software-writable control fields, taken from byte lane 0.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shared_refclk_r    <= LINK_CTRL_RESET[CTL_SHARED_REFCLK];
            link_off_r         <= LINK_CTRL_RESET[CTL_LINK_OFF];
            idle_power_level_r <= LINK_CTRL_RESET[CTL_IDLE_PWR_LO +: 2];
        end else if (wr_ctl_lo) begin
            shared_refclk_r    <= cfg_wdata[CTL_SHARED_REFCLK];
            link_off_r         <= cfg_wdata[CTL_LINK_OFF];
            idle_power_level_r <= cfg_wdata[CTL_IDLE_PWR_LO +: 2];
        end
    end

    // Retrain command: one pulse per software request or change of the disable bit.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            retrain_go_r <= 1'b0;
        end else begin
            retrain_go_r <= retrain_wr || link_off_flip;
        end
    end

    // Values derived from control fields for the training machine.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            nfts_r      <= NFTS_SEPARATE;
            l1_enable_r <= 1'b0;
        end else begin
            nfts_r      <= shared_refclk_r ? NFTS_SHARED : NFTS_SEPARATE;
            l1_enable_r <= idle_power_level_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Training-set counter for autonomous changes seen from the far end.

    ts_if ts_bus ();

    assign ts_bus.ts_valid = ts_valid;
    assign ts_bus.ts_auto  = ts_auto_change;

    ts_auto_counter u_ts_count (
        .clock (clock),
        .rst_n (rst_n),
        .ts    (ts_bus.count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Software retrain tracker.

    // Waits for training to start after a request, then for it to finish.
    always_comb begin
        trk_nxt = trk_r;
        case (trk_r)
            TRK_IDLE: begin
                if (retrain_wr) begin
                    trk_nxt = TRK_WAIT;
                end
            end
            TRK_WAIT: begin
                if (dl_down) begin
                    trk_nxt = TRK_IDLE;
                end else if (in_training(ltssm_state)) begin
                    trk_nxt = TRK_TRAIN;
                end
            end
            TRK_TRAIN: begin
                if (dl_down) begin
                    trk_nxt = TRK_IDLE;
                end else if (retrain_wr) begin
                    trk_nxt = TRK_WAIT;
                end else if (link_up(ltssm_state)) begin
                    trk_nxt = TRK_IDLE;
                end
            end
            default: begin
                trk_nxt = TRK_IDLE;
            end
        endcase
    end

    // Tracker state register.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trk_r <= TRK_IDLE;
        end else begin
            trk_r <= trk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bandwidth change events.

    // A software retrain is complete when training ends with the link up and no link down.
    logic retrain_done;
    logic auto_set;
    logic mgmt_set;
    logic auto_clr;
    logic mgmt_clr;

    assign retrain_done = (trk_r == TRK_TRAIN) && !retrain_wr && !dl_down
                          && link_up(ltssm_state);
    assign auto_set = (hw_auto_bw_change && !dl_down)
                      || ts_bus.auto_hit
                      || (phy_dsp_bw_change && phy_dsp_autonomous);
    assign mgmt_set = retrain_done
                      || (hw_reliab_bw_change && !dl_down)
                      || (phy_dsp_bw_change && !phy_dsp_autonomous);
    assign auto_clr = wr_sts_hi && cfg_wdata[16 + STS_AUTO_BW];
    assign mgmt_clr = wr_sts_hi && cfg_wdata[16 + STS_BW_MGMT];

    // Sticky flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            auto_bw_change_flag_r <= LINK_STAT_RESET[STS_AUTO_BW];
            bw_mgmt_change_flag_r <= LINK_STAT_RESET[STS_BW_MGMT];
        end else begin
            auto_bw_change_flag_r <= auto_set || (auto_bw_change_flag_r && !auto_clr);
            bw_mgmt_change_flag_r <= mgmt_set || (bw_mgmt_change_flag_r && !mgmt_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link state reporting.

    // Training indication covers the wait between a request and Recovery.
    logic training_nxt;

    assign training_nxt = in_training(ltssm_state) || (trk_nxt == TRK_WAIT);

    // Live status bits sampled every cycle.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dlink_up_indicator_r   <= LINK_STAT_RESET[STS_DLINK_UP];
            training_in_progress_r <= LINK_STAT_RESET[STS_TRAINING];
        end else begin
            dlink_up_indicator_r   <= dl_active;
            training_in_progress_r <= training_nxt;
        end
    end

    // Width and rate are captured only while the link is up, held otherwise.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            negotiated_lane_count_r <= WIDTH_RESET;
            negotiated_rate_r       <= RATE_RESET;
        end else if (link_up(ltssm_state)) begin
            negotiated_lane_count_r <= neg_width;
            negotiated_rate_r       <= neg_speed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Control word: retrain reads 0, boundary hardwired, bit 2 reserved.
    assign ctl_word = {9'h000,
                       shared_refclk_r,
                       1'b0,
                       link_off_r,
                       COMPL_BOUND_64B,
                       1'b0,
                       idle_power_level_r};

    // Status word: the undefined bit reads 0 and ignores writes.
    assign sts_word = {auto_bw_change_flag_r,
                       bw_mgmt_change_flag_r,
                       dlink_up_indicator_r,
                       SLOT_REFCLK_RESET,
                       training_in_progress_r,
                       1'b0,
                       negotiated_lane_count_r,
                       negotiated_rate_r};

    // Registered read answer one cycle after the request; other addresses read 0.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_r    <= 32'h0000_0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= cfg_rd;
            if (cfg_rd) begin
                rdata_r <= hit_dw ? {sts_word, ctl_word} : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign cfg_rdata            = rdata_r;
    assign cfg_rd_valid         = rd_valid_r;
    assign retrain_go           = retrain_go_r;
    assign link_off_request     = link_off_r;
    assign shared_refclk_select = shared_refclk_r;
    assign nfts_advertised      = nfts_r;
    assign l1_entry_enable      = l1_enable_r;

endmodule

/* File: bench/link_ctrl_status_props.sv */
// Checker for the link control and status registers, seen from the block's ports.
// Assumes the core clock and its synchronous active-low reset.
`timescale 1ns/1ns
module link_ctrl_status_props
    import link_pkg::*;
#(
    parameter logic [7:0] NFTS_SHARED   = 8'h20,
    parameter logic [7:0] NFTS_SEPARATE = 8'h80
)
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_rd_valid,
    input wire logic        dl_active,
    input wire logic        retrain_go,
    input wire logic        link_off_request,
    input wire logic        shared_refclk_select,
    input wire logic [7:0]  nfts_advertised,
    input wire logic        l1_entry_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Marks a read of the register dword that had no write beside it.
    logic hit_w;
    logic rd_map_r;
    logic rd_map_nxt;
    assign hit_w      = (cfg_addr[11:2] == 10'h02C);
    assign rd_map_nxt = rst_n && cfg_rd && !cfg_wr && hit_w;
    always_ff @(posedge clock) rd_map_r <= rd_map_nxt;

    // A write that reaches the control byte.
    sequence s_ctl_wr;
        cfg_wr && cfg_be[0] && hit_w;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_retrain_pulse: assert property (s_ctl_wr ##0 cfg_wdata[5] |=> retrain_go)
        else $error("retrain pulse missing");
    a_retrain_cause: assert property (retrain_go |-> $past(cfg_wr && cfg_be[0] && hit_w
        && (cfg_wdata[5] || cfg_wdata[4] != link_off_request)))
        else $error("retrain pulse without cause");
    a_retrain_zero: assert property (cfg_rd_valid |-> !cfg_rdata[5])
        else $error("retrain bit read as one");
    a_bound_zero: assert property (cfg_rd_valid |-> !cfg_rdata[3])
        else $error("completion boundary bit not zero");
    a_refclk_track: assert property (s_ctl_wr |=> shared_refclk_select == $past(cfg_wdata[6]))
        else $error("shared clock select not written");
    a_nfts_follow: assert property (nfts_advertised ==
        ($past(shared_refclk_select) ? NFTS_SHARED : NFTS_SEPARATE))
        else $error("advertised count does not follow clock select");
    a_off_retrains: assert property ($changed(link_off_request) |-> retrain_go)
        else $error("link off change without retrain");
    a_off_readback: assert property (rd_map_r |-> cfg_rdata[4] == link_off_request
        && cfg_rdata[6] == shared_refclk_select)
        else $error("control read differs from outputs");
    a_l1_lag: assert property (s_ctl_wr |=> ##1 l1_entry_enable == $past(cfg_wdata[1], 2))
        else $error("L1 enable does not follow idle power field");
    a_dlink_mirror: assert property (rd_map_r |-> cfg_rdata[29] == $past(dl_active, 2))
        else $error("data link bit differs from input");
    a_slot_clock: assert property (rd_map_r |-> cfg_rdata[28])
        else $error("slot clock bit not one");
endmodule

bind link_ctrl_status link_ctrl_status_props #(
    .NFTS_SHARED   (NFTS_SHARED),
    .NFTS_SEPARATE (NFTS_SEPARATE)
) props (.clock, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .cfg_rd_valid, .dl_active, .retrain_go, .link_off_request, .shared_refclk_select,
    .nfts_advertised, .l1_entry_enable);

/* File: bench/ltssm_model.sv */
// Behavioural training and data-link state machines facing the register block.
// Assumes the core clock; train_delay sets how long training takes.
`timescale 1ns/1ns
module ltssm_model
    import link_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       retrain_go,
    input  wire logic       link_off_request,
    input  wire logic [3:0] train_delay,
    output ltssm_t          ltssm_state,
    output logic            dl_active,
    output logic            dl_down
);
    logic [3:0] cnt_r;

    // Link is usable only in L0 and lost in Detect or Disabled.
    assign dl_active = (ltssm_state == LT_L0);
    assign dl_down   = (ltssm_state == LT_DETECT) || (ltssm_state == LT_DISABLED);

    // Requests act from L0, and the disable request also at the end of training and in Disabled; busy states ignore them.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ltssm_state <= LT_DETECT;
            cnt_r       <= 4'h3;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else begin
            case (ltssm_state)
                LT_DETECT: begin
                    ltssm_state <= LT_CONFIG;
                    cnt_r       <= train_delay;
                end
                LT_CONFIG, LT_RECOVERY: begin
                    ltssm_state <= link_off_request ? LT_DISABLED : LT_L0;
                end
                LT_DISABLED: begin
                    if (!link_off_request) ltssm_state <= LT_DETECT;
                end
                default: begin
                    if (retrain_go || link_off_request) begin
                        ltssm_state <= LT_RECOVERY;
                        cnt_r       <= train_delay;
                    end
                end
            endcase
        end
    end
endmodule

/* File: bench/test_pcie_link_ctrl_status.sv */
// Self-checking bench for the link control and status registers.
// Assumes the training model in ltssm_model.sv drives the link state inputs.
`timescale 1ns/1ns
module test_pcie_link_ctrl_status;
    import link_pkg::*;
    typedef struct packed {
        logic [15:0] wr;
        logic [15:0] ctl;
        logic        l1;
        logic [7:0]  nfts;
    } row_t;
    localparam logic [7:0] SH = 8'h21;
    localparam logic [7:0] SE = 8'h84;
    localparam logic [31:0] UP = 32'h31020000;
    logic        clock, rst_n, cfg_wr, cfg_rd, cfg_rd_valid, dl_active, dl_down, go;
    logic        ts_valid, ts_auto_change, phy_dsp_autonomous, retrain_go, link_off_request;
    logic        shared_refclk_select, l1_entry_enable;
    logic [2:0]  ev;
    logic [3:0]  cfg_be, neg_speed, train_delay;
    logic [5:0]  neg_width;
    logic [7:0]  nfts_advertised;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, rv;
    ltssm_t      ltssm_state;
    int          miscompares, num_checks;
    row_t        rows [6] = '{'{16'h0040, 16'h0040, 1'b0, SH}, '{16'h0042, 16'h0042, 1'b1, SH},
        '{16'h0003, 16'h0003, 1'b1, SE}, '{16'h0001, 16'h0001, 1'b0, SE},
        '{16'hFF8F, 16'h0003, 1'b1, SE}, '{16'h0000, 16'h0000, 1'b0, SE}};

    link_ctrl_status #(.NFTS_SHARED(SH), .NFTS_SEPARATE(SE)) uut (.clock, .rst_n, .cfg_wr,
        .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .ltssm_state,
        .dl_active, .dl_down, .neg_width, .neg_speed, .ts_valid, .ts_auto_change,
        .hw_auto_bw_change(ev[0]), .hw_reliab_bw_change(ev[1]), .phy_dsp_bw_change(ev[2]),
        .phy_dsp_autonomous, .retrain_go, .link_off_request, .shared_refclk_select,
        .nfts_advertised, .l1_entry_enable);
    ltssm_model partner (.clock, .rst_n, .retrain_go, .link_off_request, .train_delay,
        .ltssm_state, .dl_active, .dl_down);

    ////////////////////////////////////////////////////////////////////////
    // Clock of 8 ns and a watchdog far beyond the expected run.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Writes take one edge; go keeps the retrain pulse seen afterwards.
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        cfg_wr = 1'b1;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clock);
        cfg_wr = 1'b0;
        go = retrain_go;
    endtask
    // A read answers one cycle later; a missing answer yields a poison value.
    // One idle edge follows, so the next read raises its strobe anew.
    task automatic rd();
        cfg_rd = 1'b1;
        @(negedge clock);
        cfg_rd = 1'b0;
        rv = (cfg_rd_valid === 1'b1) ? cfg_rdata : 32'hDEADBEEF;
        @(negedge clock);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Polls until the training bit drops, bounded.
    task automatic trained();
        rd();
        for (int i = 0; i < 60 && rv[27] !== 1'b0; i++) rd();
    endtask
    task automatic kick(input int i);
        ev[i] = 1'b1;
        @(negedge clock);
        ev = 3'h0;
    endtask
    task automatic ts(input int n, input logic m);
        for (int i = 0; i < n; i++) begin
            ts_valid = 1'b1;
            ts_auto_change = m;
            @(negedge clock);
            ts_valid = 1'b0;
            @(negedge clock);
        end
    endtask
    // Reads both flags, then clears them by writing ones.
    task automatic flags(input logic [31:0] exp);
        idle(2);
        rd();
        chk(rv & 32'hC0000000, exp);
        wr(4'h8, 32'hC0000000);
        rd();
        chk(rv & 32'hC0000000, 32'h0);
    endtask
    task automatic print_verdict();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, cfg_wr, cfg_rd, ts_valid, ts_auto_change, phy_dsp_autonomous, ev} = '0;
        {cfg_be, cfg_wdata, go} = '0;
        cfg_addr = 12'h0B0;
        neg_width = 6'h10;
        neg_speed = 4'h2;
        train_delay = 4'h2;
        idle(8);
        rst_n = 1'b1;
        chk(cfg_rdata, 32'h0);
        idle(30);
        rd();
        chk(rv, UP);
        foreach (rows[i]) begin
            wr(4'h1, {16'h0, rows[i].wr});
            idle(2);
            rd();
            chk(rv, UP | {16'h0, rows[i].ctl});
            chk({31'h0, l1_entry_enable}, {31'h0, rows[i].l1});
            chk({24'h0, nfts_advertised}, {24'h0, rows[i].nfts});
        end
        $display("register rows done");
        wr(4'h1, 32'h20);
        chk({31'h0, go}, 32'h1);
        rd();
        chk(rv & 32'h08000020, 32'h08000000);
        trained();
        chk(rv & 32'hC8000000, 32'h40000000);
        wr(4'h8, 32'h0);
        rd();
        chk(rv & 32'h40000000, 32'h40000000);
        flags(32'h40000000);
        train_delay = 4'hC;
        wr(4'h1, 32'h20);
        idle(4);
        wr(4'h1, 32'h20);
        trained();
        flags(32'h40000000);
        $display("retrain tests done");
        kick(0);
        flags(32'h80000000);
        phy_dsp_autonomous = 1'b1;
        kick(2);
        flags(32'h80000000);
        phy_dsp_autonomous = 1'b0;
        kick(2);
        flags(32'h40000000);
        kick(1);
        flags(32'h40000000);
        ts(7, 1'b1);
        ts(1, 1'b0);
        flags(32'h0);
        ts(8, 1'b1);
        flags(32'h80000000);
        $display("flag tests done");
        wr(4'h1, 32'h10);
        chk({31'h0, go}, 32'h1);
        rd();
        chk(rv & 32'h10, 32'h10);
        idle(25);
        rd();
        chk(rv & 32'h20000010, 32'h10);
        chk({28'h0, ltssm_state}, 32'h7);
        wr(4'h1, 32'h0);
        chk({31'h0, go}, 32'h1);
        idle(6);
        trained();
        chk(rv & 32'h20000000, 32'h20000000);
        wr(4'hC, 32'h3FFF0000);
        rd();
        chk(rv & 32'hFBFFFFFF, UP);
        cfg_addr = 12'h0B4;
        rd();
        chk(rv, 32'h0);
        cfg_addr = 12'h0B0;
        $display("link off and read-only tests done");
        // Mid-run reset returns control outputs and status to their reset values.
        wr(4'h1, 32'h42);
        idle(2);
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        rd();
        chk(rv, 32'h10000000);
        chk({23'h0, l1_entry_enable, nfts_advertised}, {23'h0, 1'b0, SE});
        $display("reset test done");
        print_verdict();
    end
endmodule
